// ==== design/nvmeps_top.v ====
`timescale 1ns/10ps
`include "nvmeps_regs.vh"
module nvmeps_top (
  // clock and reset
  input  wire        mclk,
  input  wire        rst,
  // register port
  input  wire [3:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [7:0]  reg_rdata,
  // debug memory port
  input  wire [15:0] dbg_addr,
  input  wire [7:0]  dbg_wdata,
  input  wire        dbg_wr,
  input  wire        dbg_rd,
  output reg  [7:0]  dbg_rdata,
  output reg         dbg_stall,
  // status
  output reg         nvm_busy,
  output reg         memory_interface_enabled
);
  localparam [1:0] ST_IDLE = 2'd0;
  localparam [1:0] ST_WAIT = 2'd1;
  localparam [1:0] ST_CRC  = 2'd2;
  localparam [1:0] ST_CEND = 2'd3;
  localparam integer OP_CYC_N = `NVMEPS_OP_CYC;
  localparam [7:0] OP_CYC  = OP_CYC_N[7:0];

  // ==========================================
  // arrays
  reg [7:0]  flash_mem [0:`NVMEPS_FLASH_SZ-1];
  reg [7:0]  ee_mem    [0:`NVMEPS_EE_SZ-1];
  reg [7:0]  fuse_mem  [0:`NVMEPS_FUSE_SZ-1];
  reg [7:0]  usig_mem  [0:`NVMEPS_USIG_SZ-1];
  reg [15:0] fbuf      [0:`NVMEPS_FPG_WORDS-1];
  reg [7:0]  ebuf      [0:`NVMEPS_EPG_SZ-1];
  reg [7:0]  lock_bits;
  reg [7:0]  flo_tmp;

  // ==========================================
  // control state
  reg [6:0]  cmd;
  reg [15:0] addr_reg;
  reg [15:0] data_reg;
  reg [1:0]  state;
  reg [6:0]  op_cmd;
  reg [15:0] op_addr;
  reg [7:0]  op_data;
  reg [7:0]  op_cnt;
  reg [8:0]  crc_idx;
  reg [8:0]  crc_end;
  reg        crc_clear;
  reg        crc_feed;
  reg [7:0]  crc_byte;
  wire [15:0] crc_val;
  integer    i;

  function [2:0] region;
    input [15:0] a;
    begin
      region = a[14:12];
    end
  endfunction

  function in_boot;
    input [15:0] a;
    begin
      in_boot = ({1'b0, a[7:0]} >= `NVMEPS_BOOT_BASE);
    end
  endfunction

  // commands started by the execute bit
  function is_exec_cmd;
    input [6:0] c;
    begin
      case (c)
        `NVMEPS_C_CHIP_ER, `NVMEPS_C_ER_FBUF, `NVMEPS_C_ER_EBUF,
        `NVMEPS_C_FCRC, `NVMEPS_C_ACRC, `NVMEPS_C_BCRC,
        `NVMEPS_C_ER_FPG, `NVMEPS_C_ER_APG, `NVMEPS_C_ER_BPG,
        `NVMEPS_C_ER_USIG, `NVMEPS_C_ER_EPG: is_exec_cmd = 1'b1;
        default: is_exec_cmd = 1'b0;
      endcase
    end
  endfunction

  // commands started by a debug write that keep memory busy
  function is_wr_cmd;
    input [6:0] c;
    begin
      case (c)
        `NVMEPS_C_ER_FPG, `NVMEPS_C_WR_FPG, `NVMEPS_C_EW_FPG,
        `NVMEPS_C_ER_APP, `NVMEPS_C_ER_APG, `NVMEPS_C_WR_APG, `NVMEPS_C_EW_APG,
        `NVMEPS_C_ER_BOOT, `NVMEPS_C_ER_BPG, `NVMEPS_C_WR_BPG, `NVMEPS_C_EW_BPG,
        `NVMEPS_C_ER_USIG, `NVMEPS_C_WR_USIG, `NVMEPS_C_WR_FUSE,
        `NVMEPS_C_WR_LOCK, `NVMEPS_C_ER_EE, `NVMEPS_C_ER_EPG,
        `NVMEPS_C_WR_EPG, `NVMEPS_C_EW_EPG: is_wr_cmd = 1'b1;
        default: is_wr_cmd = 1'b0;
      endcase
    end
  endfunction

  // section-specific page commands started by a debug write refuse addresses outside their section
  function addr_ok;
    input [6:0]  c;
    input [15:0] a;
    begin
      case (c)
        `NVMEPS_C_ER_APG, `NVMEPS_C_WR_APG, `NVMEPS_C_EW_APG, `NVMEPS_C_ER_APP:
          addr_ok = (region(a) == `NVMEPS_G_FLASH) && !in_boot(a);
        `NVMEPS_C_ER_BPG, `NVMEPS_C_WR_BPG, `NVMEPS_C_EW_BPG, `NVMEPS_C_ER_BOOT:
          addr_ok = (region(a) == `NVMEPS_G_FLASH) && in_boot(a);
        `NVMEPS_C_ER_FPG, `NVMEPS_C_WR_FPG, `NVMEPS_C_EW_FPG:
          addr_ok = (region(a) == `NVMEPS_G_FLASH);
        `NVMEPS_C_ER_EE, `NVMEPS_C_ER_EPG, `NVMEPS_C_WR_EPG, `NVMEPS_C_EW_EPG:
          addr_ok = (region(a) == `NVMEPS_G_EE);
        `NVMEPS_C_WR_FUSE: addr_ok = (region(a) == `NVMEPS_G_FUSE);
        `NVMEPS_C_WR_LOCK: addr_ok = (region(a) == `NVMEPS_G_LOCK);
        default: addr_ok = 1'b1;
      endcase
    end
  endfunction

  // ==========================================
  // qualifiers
  wire rw_lock  = (lock_bits[1:0] == 2'b00);
  wire preserve = ~fuse_mem[`NVMEPS_PRESV_FUSE][`NVMEPS_PRESV_BIT];
  wire idle     = (state == ST_IDLE);
  wire cmd_free = (cmd == `NVMEPS_C_CHIP_ER) || (cmd == `NVMEPS_C_FCRC);
  wire exec_go  = reg_wr && (reg_addr == `NVMEPS_R_CTRL_FIRST) && reg_wdata[`NVMEPS_B_EXEC]
                  && idle && is_exec_cmd(cmd) && (!rw_lock || cmd_free);
  wire dbg_ok   = memory_interface_enabled && idle && !rw_lock;
  wire wr_go    = dbg_wr && dbg_ok && is_wr_cmd(cmd) && addr_ok(cmd, dbg_addr);
  wire ld_f     = dbg_wr && dbg_ok && (cmd == `NVMEPS_C_LD_FBUF)
                  && (region(dbg_addr) == `NVMEPS_G_FLASH);
  wire ld_e     = dbg_wr && dbg_ok && (cmd == `NVMEPS_C_LD_EBUF)
                  && (region(dbg_addr) == `NVMEPS_G_EE);
  wire [7:0]  fbase = {op_addr[7:4], 4'h0};
  wire [5:0]  ebase = {op_addr[5:3], 3'h0};

  nvmeps_crc u_crc (
    .mclk  (mclk),
    .rst   (rst),
    .clear (crc_clear),
    .feed  (crc_feed),
    .data  (crc_byte),
    .crc   (crc_val)
  );

  // ==========================================
  // register port and sequencer
  always @(posedge mclk) begin
    if (rst) begin
      cmd       <= `NVMEPS_C_NOP;
      addr_reg  <= 16'h0000;
      data_reg  <= 16'h0000;
      state     <= ST_IDLE;
      op_cmd    <= `NVMEPS_C_NOP;
      op_addr   <= 16'h0000;
      op_data   <= 8'h00;
      op_cnt    <= 8'h00;
      crc_idx   <= 9'h000;
      crc_end   <= 9'h000;
      crc_clear <= 1'b0;
      crc_feed  <= 1'b0;
      crc_byte  <= 8'h00;
      reg_rdata <= 8'h00;
      nvm_busy  <= 1'b0;
      memory_interface_enabled <= 1'b1;
    end else begin
      crc_clear <= 1'b0;
      crc_feed  <= 1'b0;
      reg_rdata <= 8'h00;
      if (reg_rd) begin
        case (reg_addr)
          `NVMEPS_R_DATA_LO: reg_rdata <= data_reg[7:0];
          `NVMEPS_R_DATA_HI: reg_rdata <= data_reg[15:8];
          `NVMEPS_R_CMD:     reg_rdata <= {1'b0, cmd};
          `NVMEPS_R_STATUS: begin
            reg_rdata[`NVMEPS_B_BUSY]   <= nvm_busy;
            reg_rdata[`NVMEPS_B_IFEN]   <= memory_interface_enabled;
            reg_rdata[`NVMEPS_B_RWLOCK] <= rw_lock;
          end
          `NVMEPS_R_ADDR_LO: reg_rdata <= addr_reg[7:0];
          `NVMEPS_R_ADDR_HI: reg_rdata <= addr_reg[15:8];
          default:           reg_rdata <= 8'h00;
        endcase
      end
      // command and address held steady while an operation runs
      if (reg_wr && idle) begin
        case (reg_addr)
          `NVMEPS_R_CMD:     cmd <= reg_wdata[6:0];
          `NVMEPS_R_ADDR_LO: addr_reg[7:0] <= reg_wdata;
          `NVMEPS_R_ADDR_HI: addr_reg[15:8] <= reg_wdata;
          default:           cmd <= cmd;
        endcase
      end
      case (state)
        ST_IDLE: begin
          if (exec_go) begin
            op_cmd   <= cmd;
            op_addr  <= addr_reg;
            op_cnt   <= OP_CYC;
            nvm_busy <= 1'b1;
            state    <= ST_WAIT;
            crc_clear <= 1'b1;
            crc_idx  <= (cmd == `NVMEPS_C_BCRC) ? `NVMEPS_BOOT_BASE : 9'h000;
            crc_end  <= (cmd == `NVMEPS_C_ACRC) ? `NVMEPS_APP_END : `NVMEPS_FLASH_END;
            if (cmd == `NVMEPS_C_CHIP_ER || cmd == `NVMEPS_C_FCRC) begin
              memory_interface_enabled <= 1'b0;
            end
            if (cmd == `NVMEPS_C_FCRC || cmd == `NVMEPS_C_ACRC || cmd == `NVMEPS_C_BCRC) begin
              state <= ST_CRC;
            end
          end else if (wr_go) begin
            op_cmd   <= cmd;
            op_addr  <= dbg_addr;
            op_data  <= dbg_wdata;
            op_cnt   <= OP_CYC;
            nvm_busy <= 1'b1;
            state    <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (op_cnt == 8'h01) begin
            state    <= ST_IDLE;
            nvm_busy <= 1'b0;
            memory_interface_enabled <= 1'b1;
          end
          op_cnt <= op_cnt - 8'h01;
        end
        ST_CRC: begin
          crc_feed <= 1'b1;
          crc_byte <= flash_mem[crc_idx[7:0]];
          crc_idx  <= crc_idx + 9'h001;
          if (crc_idx == crc_end) begin
            state <= ST_CEND;
          end
        end
        ST_CEND: begin
          // last byte lands in the engine this cycle; take result one later
          if (!crc_feed) begin
            data_reg <= crc_val;
            state    <= ST_IDLE;
            nvm_busy <= 1'b0;
            memory_interface_enabled <= 1'b1;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ==========================================
  // memory effects, applied at the end of the busy period; buffer loads land on the debug write itself
  always @(posedge mclk) begin
    if (state == ST_WAIT && op_cnt == 8'h01) begin
      case (op_cmd)
        `NVMEPS_C_CHIP_ER: begin
          for (i = 0; i < `NVMEPS_FLASH_SZ; i = i + 1) begin
            flash_mem[i] <= `NVMEPS_ERASED8;
          end
          lock_bits <= `NVMEPS_ERASED8;
          for (i = 0; i < `NVMEPS_EE_SZ; i = i + 1) begin
            if (!preserve) begin
              ee_mem[i] <= `NVMEPS_ERASED8;
            end
          end
        end
        `NVMEPS_C_ER_FBUF: begin
          for (i = 0; i < `NVMEPS_FPG_WORDS; i = i + 1) begin
            fbuf[i] <= `NVMEPS_ERASED16;
          end
        end
        `NVMEPS_C_ER_EBUF: begin
          for (i = 0; i < `NVMEPS_EPG_SZ; i = i + 1) begin
            ebuf[i] <= `NVMEPS_ERASED8;
          end
        end
        `NVMEPS_C_ER_FPG, `NVMEPS_C_ER_APG, `NVMEPS_C_ER_BPG: begin
          for (i = 0; i < 2 * `NVMEPS_FPG_WORDS; i = i + 1) begin
            flash_mem[fbase + i[7:0]] <= `NVMEPS_ERASED8;
          end
        end
        `NVMEPS_C_WR_FPG, `NVMEPS_C_WR_APG, `NVMEPS_C_WR_BPG: begin
          // programming only clears bits
          for (i = 0; i < 2 * `NVMEPS_FPG_WORDS; i = i + 1) begin
            flash_mem[fbase + i[7:0]] <= flash_mem[fbase + i[7:0]]
              & (i[0] ? fbuf[i / 2][15:8] : fbuf[i / 2][7:0]);
          end
        end
        `NVMEPS_C_EW_FPG, `NVMEPS_C_EW_APG, `NVMEPS_C_EW_BPG: begin
          for (i = 0; i < 2 * `NVMEPS_FPG_WORDS; i = i + 1) begin
            flash_mem[fbase + i[7:0]] <= i[0] ? fbuf[i / 2][15:8] : fbuf[i / 2][7:0];
          end
        end
        `NVMEPS_C_ER_APP, `NVMEPS_C_ER_BOOT: begin
          for (i = 0; i < `NVMEPS_FLASH_SZ; i = i + 1) begin
            if ((i >= `NVMEPS_BOOT_BASE) == (op_cmd == `NVMEPS_C_ER_BOOT)) begin
              flash_mem[i] <= `NVMEPS_ERASED8;
            end
          end
        end
        `NVMEPS_C_ER_USIG: begin
          for (i = 0; i < `NVMEPS_USIG_SZ; i = i + 1) begin
            usig_mem[i] <= `NVMEPS_ERASED8;
          end
        end
        `NVMEPS_C_WR_USIG: begin
          for (i = 0; i < `NVMEPS_USIG_SZ; i = i + 1) begin
            usig_mem[i] <= usig_mem[i] & (i[0] ? fbuf[i / 2][15:8] : fbuf[i / 2][7:0]);
          end
        end
        `NVMEPS_C_ER_EE: begin
          for (i = 0; i < `NVMEPS_EE_SZ; i = i + 1) begin
            ee_mem[i] <= `NVMEPS_ERASED8;
          end
        end
        `NVMEPS_C_ER_EPG, `NVMEPS_C_WR_EPG, `NVMEPS_C_EW_EPG: begin
          for (i = 0; i < `NVMEPS_EPG_SZ; i = i + 1) begin
            if (op_cmd == `NVMEPS_C_ER_EPG) begin
              ee_mem[ebase + i[5:0]] <= `NVMEPS_ERASED8;
            end else if (op_cmd == `NVMEPS_C_WR_EPG) begin
              ee_mem[ebase + i[5:0]] <= ee_mem[ebase + i[5:0]] & ebuf[i];
            end else begin
              ee_mem[ebase + i[5:0]] <= ebuf[i];
            end
          end
        end
        `NVMEPS_C_WR_FUSE: fuse_mem[op_addr[2:0]] <= fuse_mem[op_addr[2:0]] & op_data;
        `NVMEPS_C_WR_LOCK: lock_bits <= lock_bits & op_data;
        default: lock_bits <= lock_bits;
      endcase
    end else begin
      if (ld_f && !dbg_addr[0]) begin
        flo_tmp <= dbg_wdata;
      end
      if (ld_f && dbg_addr[0]) begin
        fbuf[dbg_addr[3:1]] <= {dbg_wdata, flo_tmp};
      end
      if (ld_e) begin
        ebuf[dbg_addr[2:0]] <= dbg_wdata;
      end
    end
  end

  // ==========================================
  // debug reads and load stall
  always @(posedge mclk) begin
    if (rst) begin
      dbg_rdata <= 8'h00;
      dbg_stall <= 1'b0;
    end else begin
      dbg_stall <= ld_f || ld_e;
      dbg_rdata <= 8'h00;
      // blocked reads answer zero: busy, path cut or locked
      if (dbg_rd && dbg_ok) begin
        case (region(dbg_addr))
          `NVMEPS_G_FLASH:
            if (cmd == `NVMEPS_C_READ) dbg_rdata <= flash_mem[dbg_addr[7:0]];
          `NVMEPS_G_EE:
            if (cmd == `NVMEPS_C_READ || cmd == `NVMEPS_C_RD_EE) dbg_rdata <= ee_mem[dbg_addr[5:0]];
          `NVMEPS_G_FUSE:
            if (cmd == `NVMEPS_C_READ || cmd == `NVMEPS_C_RD_FUSE) dbg_rdata <= fuse_mem[dbg_addr[2:0]];
          `NVMEPS_G_USIG:
            if (cmd == `NVMEPS_C_READ || cmd == `NVMEPS_C_RD_USIG) dbg_rdata <= usig_mem[dbg_addr[3:0]];
          `NVMEPS_G_PSIG:
            if (cmd == `NVMEPS_C_READ || cmd == `NVMEPS_C_RD_PSIG)
              dbg_rdata <= {4'h0, dbg_addr[3:0]} ^ `NVMEPS_PSIG_XOR;
          `NVMEPS_G_LOCK:
            if (cmd == `NVMEPS_C_READ || cmd == `NVMEPS_C_RD_FUSE) dbg_rdata <= lock_bits;
          default: dbg_rdata <= 8'h00;
        endcase
      end
    end
  end
endmodule

// ==== design/nvmeps_regs.vh ====
`ifndef NVMEPS_REGS_VH
`define NVMEPS_REGS_VH
// ==========================================
// register map, byte addresses on the plain port
`define NVMEPS_R_DATA_LO   4'h0
`define NVMEPS_R_DATA_HI   4'h1
`define NVMEPS_R_CMD       4'h2
`define NVMEPS_R_CTRL_FIRST 4'h3
`define NVMEPS_R_STATUS    4'h4
`define NVMEPS_R_ADDR_LO   4'h5
`define NVMEPS_R_ADDR_HI   4'h6
`define NVMEPS_B_EXEC      0
`define NVMEPS_B_BUSY      7
`define NVMEPS_B_IFEN      1
`define NVMEPS_B_RWLOCK    0
// ==========================================
// command codes
`define NVMEPS_C_NOP       7'h00
`define NVMEPS_C_CHIP_ER   7'h40
`define NVMEPS_C_READ      7'h43
`define NVMEPS_C_LD_FBUF   7'h23
`define NVMEPS_C_ER_FBUF   7'h26
`define NVMEPS_C_ER_FPG    7'h2B
`define NVMEPS_C_WR_FPG    7'h2E
`define NVMEPS_C_EW_FPG    7'h2F
`define NVMEPS_C_FCRC      7'h78
`define NVMEPS_C_ER_APP    7'h20
`define NVMEPS_C_ER_APG    7'h22
`define NVMEPS_C_WR_APG    7'h24
`define NVMEPS_C_EW_APG    7'h25
`define NVMEPS_C_ACRC      7'h38
`define NVMEPS_C_ER_BOOT   7'h68
`define NVMEPS_C_ER_BPG    7'h2A
`define NVMEPS_C_WR_BPG    7'h2C
`define NVMEPS_C_EW_BPG    7'h2D
`define NVMEPS_C_BCRC      7'h39
`define NVMEPS_C_RD_USIG   7'h01
`define NVMEPS_C_ER_USIG   7'h18
`define NVMEPS_C_WR_USIG   7'h1A
`define NVMEPS_C_RD_PSIG   7'h02
`define NVMEPS_C_RD_FUSE   7'h07
`define NVMEPS_C_WR_FUSE   7'h4C
`define NVMEPS_C_WR_LOCK   7'h08
`define NVMEPS_C_LD_EBUF   7'h33
`define NVMEPS_C_ER_EBUF   7'h36
`define NVMEPS_C_ER_EE     7'h30
`define NVMEPS_C_ER_EPG    7'h32
`define NVMEPS_C_WR_EPG    7'h34
`define NVMEPS_C_EW_EPG    7'h35
`define NVMEPS_C_RD_EE     7'h06
// ==========================================
// debug address space: region in bits 14:12
`define NVMEPS_G_FLASH     3'h0
`define NVMEPS_G_EE        3'h1
`define NVMEPS_G_FUSE      3'h2
`define NVMEPS_G_USIG      3'h3
`define NVMEPS_G_PSIG      3'h4
`define NVMEPS_G_LOCK      3'h5
`define NVMEPS_FLASH_SZ    256
`define NVMEPS_BOOT_BASE   9'h0C0
`define NVMEPS_FLASH_END   9'h0FF
`define NVMEPS_APP_END     9'h0BF
`define NVMEPS_EE_SZ       64
`define NVMEPS_FPG_WORDS   8
`define NVMEPS_EPG_SZ      8
`define NVMEPS_FUSE_SZ     8
`define NVMEPS_USIG_SZ     16
`define NVMEPS_PSIG_XOR    8'h5A
`define NVMEPS_ERASED8     8'hFF
`define NVMEPS_ERASED16    16'hFFFF
`define NVMEPS_PRESV_FUSE  5
`define NVMEPS_PRESV_BIT   3
// ==========================================
// timing and crc
`define NVMEPS_OP_NS       1000
`define NVMEPS_CLK_NS      4
`define NVMEPS_OP_CYC      (`NVMEPS_OP_NS / `NVMEPS_CLK_NS)
`define NVMEPS_CRC_POLY    16'h1021
`define NVMEPS_CRC_INIT    16'hFFFF
`endif

// ==== design/nvmeps_crc.v ====
`timescale 1ns/10ps
`include "nvmeps_regs.vh"
module nvmeps_crc (
  // clock and reset
  input  wire        mclk,
  input  wire        rst,
  // byte stream
  input  wire        clear,
  input  wire        feed,
  input  wire [7:0]  data,
  // running checksum
  output reg  [15:0] crc
);
  reg     [15:0] next_crc;
  integer        b;

  always @* begin
    next_crc = crc ^ {data, 8'h00};
    for (b = 0; b < 8; b = b + 1) begin
      if (next_crc[15]) begin
        next_crc = {next_crc[14:0], 1'b0} ^ `NVMEPS_CRC_POLY;
      end else begin
        next_crc = {next_crc[14:0], 1'b0};
      end
    end
  end

  always @(posedge mclk) begin
    if (rst || clear) begin
      crc <= `NVMEPS_CRC_INIT;
    end else if (feed) begin
      crc <= next_crc;
    end
  end
endmodule

// ==== bench/nvmeps_top_props.sv ====
`timescale 1ns/10ps
`include "nvmeps_regs.vh"
module nvmeps_top_props (
  // clock and reset
  input wire        mclk,
  input wire        rst,
  // register port
  input wire [3:0]  reg_addr,
  input wire [7:0]  reg_wdata,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [7:0]  reg_rdata,
  // debug port and status
  input wire [15:0] dbg_addr,
  input wire [7:0]  dbg_wdata,
  input wire        dbg_wr,
  input wire        dbg_rd,
  input wire [7:0]  dbg_rdata,
  input wire        dbg_stall,
  input wire        nvm_busy,
  input wire        memory_interface_enabled
);
  // ==========================================
  // shadow of the command register
  reg  [6:0] cmd;
  reg  [8:0] bcnt;
  wire       exec    = reg_wr && reg_addr == `NVMEPS_R_CTRL_FIRST && reg_wdata[`NVMEPS_B_EXEC] && !nvm_busy;
  wire       is_crc  = cmd == `NVMEPS_C_FCRC || cmd == `NVMEPS_C_ACRC || cmd == `NVMEPS_C_BCRC;
  wire       is_load = cmd == `NVMEPS_C_LD_FBUF || cmd == `NVMEPS_C_LD_EBUF;
  wire       is_open = cmd == `NVMEPS_C_CHIP_ER || cmd == `NVMEPS_C_FCRC;
  always @(posedge mclk) begin
    if (rst) begin
      cmd  <= 7'h00;
      bcnt <= 9'h000;
    end else begin
      if (reg_wr && reg_addr == `NVMEPS_R_CMD && !nvm_busy) begin
        cmd <= reg_wdata[6:0];
      end
      // crc length depends on section size, so only fixed ops are timed
      bcnt <= nvm_busy ? bcnt + 9'h001 : 9'h000;
    end
  end
  // ==========================================
  // properties
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  property p_busy_len; $fell(nvm_busy) && !is_crc |-> bcnt == `NVMEPS_OP_CYC; endproperty
  property p_exec_iface; exec && is_open |=> nvm_busy && !memory_interface_enabled; endproperty
  property p_iface; !memory_interface_enabled |-> nvm_busy; endproperty
  property p_rd_block; dbg_rd && nvm_busy |=> dbg_rdata == 8'h00; endproperty
  property p_dbg_idle; dbg_rdata != 8'h00 |-> $past(dbg_rd); endproperty
  property p_reg_idle; reg_rdata != 8'h00 |-> $past(reg_rd); endproperty
  property p_status;
    reg_rd && reg_addr == `NVMEPS_R_STATUS |=>
      reg_rdata[7] == $past(nvm_busy) && reg_rdata[1] == $past(memory_interface_enabled);
  endproperty
  property p_stall; dbg_stall |-> $past(dbg_wr) && $past(is_load); endproperty
  property p_load_quiet; dbg_wr && is_load && !nvm_busy |=> !nvm_busy; endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
  a_exec_iface: assert property (p_exec_iface) else $error("interface not cut");
  a_iface: assert property (p_iface) else $error("interface low while idle");
  a_rd_block: assert property (p_rd_block) else $error("read while busy");
  a_dbg_idle: assert property (p_dbg_idle) else $error("debug data without read");
  a_reg_idle: assert property (p_reg_idle) else $error("register data without read");
  a_status: assert property (p_status) else $error("status bits wrong");
  a_stall: assert property (p_stall) else $error("stall without load");
  a_load_quiet: assert property (p_load_quiet) else $error("load set busy");
  c_chip: cover property (exec && cmd == `NVMEPS_C_CHIP_ER);
  c_stall: cover property (dbg_stall);
  c_crc: cover property ($fell(nvm_busy) && is_crc);
endmodule
bind nvmeps_top nvmeps_top_props u_props (
  .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dbg_addr(dbg_addr), .dbg_wdata(dbg_wdata),
  .dbg_wr(dbg_wr), .dbg_rd(dbg_rd), .dbg_rdata(dbg_rdata), .dbg_stall(dbg_stall),
  .nvm_busy(nvm_busy), .memory_interface_enabled(memory_interface_enabled));

// ==== bench/nvmeps_prog.sv ====
`timescale 1ns/10ps
module nvmeps_prog (
  // clock
  input  wire        mclk,
  // debug memory port
  output reg  [15:0] dbg_addr,
  output reg  [7:0]  dbg_wdata,
  output reg         dbg_wr,
  output reg         dbg_rd,
  input  wire [7:0]  dbg_rdata,
  input  wire        dbg_stall
);
  integer slow;
  initial begin
    dbg_addr  = 16'h0000;
    dbg_wdata = 8'h00;
    dbg_wr    = 1'b0;
    dbg_rd    = 1'b0;
    slow      = 0;
  end
  // ==========================================
  // accesses; released lines show the inverse, never the old value
  task dwr(input [15:0] a, input [7:0] v);
    integer n;
    begin
      @(posedge mclk);
      dbg_addr  <= a;
      dbg_wdata <= v;
      dbg_wr    <= 1'b1;
      @(posedge mclk);
      dbg_wr    <= 1'b0;
      dbg_addr  <= ~a;
      dbg_wdata <= ~v;
      #1;
      n = 0;
      while (dbg_stall === 1'b1 && n < 8) begin
        @(posedge mclk);
        #1;
        n = n + 1;
      end
      // a stall that never ends is a failure, not a hang
      if (dbg_stall === 1'b1) begin
        nvmeps_top_tb.fail_count = nvmeps_top_tb.fail_count + 1;
        nvmeps_top_tb.give_verdict;
      end
      repeat (slow) @(posedge mclk);
    end
  endtask
  task dword(input [15:0] a, input [15:0] w);
    begin
      dwr(a, w[7:0]);
      dwr(a | 16'h0001, w[15:8]);
    end
  endtask
  task drd(input [15:0] a, output [7:0] v);
    begin
      @(posedge mclk);
      dbg_addr <= a;
      dbg_rd   <= 1'b1;
      @(posedge mclk);
      dbg_rd   <= 1'b0;
      dbg_addr <= ~a;
      #1 v = dbg_rdata;
    end
  endtask
endmodule

// ==== bench/nvmeps_top_tb.sv ====
`timescale 1ns/10ps
`include "nvmeps_regs.vh"
module nvmeps_top_tb;
  reg         mclk;
  reg         rst;
  reg  [3:0]  reg_addr;
  reg  [7:0]  reg_wdata;
  reg         reg_wr;
  reg         reg_rd;
  wire [7:0]  reg_rdata;
  wire [15:0] dbg_addr;
  wire [7:0]  dbg_wdata;
  wire        dbg_wr;
  wire        dbg_rd;
  wire [7:0]  dbg_rdata;
  wire        dbg_stall;
  wire        nvm_busy;
  wire        memory_interface_enabled;
  integer     fail_count;
  integer     cmp_count;
  reg  [7:0]  d;
  reg  [15:0] crc;
  nvmeps_top DUT (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dbg_addr(dbg_addr), .dbg_wdata(dbg_wdata), .dbg_wr(dbg_wr),
    .dbg_rd(dbg_rd), .dbg_rdata(dbg_rdata), .dbg_stall(dbg_stall), .nvm_busy(nvm_busy),
    .memory_interface_enabled(memory_interface_enabled));
  nvmeps_prog prog (.mclk(mclk), .dbg_addr(dbg_addr), .dbg_wdata(dbg_wdata), .dbg_wr(dbg_wr),
    .dbg_rd(dbg_rd), .dbg_rdata(dbg_rdata), .dbg_stall(dbg_stall));
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // ==========================================
  // checking and register access
  task give_verdict;
    begin
      if (fail_count == 0 && cmp_count > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  task chk(input [7:0] seen, input [7:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
        fail_count = fail_count + 1;
        $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task rwr(input [3:0] a, input [7:0] v);
    begin
      @(posedge mclk);
      reg_addr  <= a;
      reg_wdata <= v;
      reg_wr    <= 1'b1;
      @(posedge mclk);
      reg_wr    <= 1'b0;
    end
  endtask
  task rrd(input [3:0] a, output [7:0] v);
    begin
      @(posedge mclk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge mclk);
      reg_rd   <= 1'b0;
      #1 v = reg_rdata;
    end
  endtask
  // polls status until idle with the memory path back; bounded
  task wait_idle;
    integer n;
    begin
      n = 0;
      rrd(`NVMEPS_R_STATUS, d);
      while (d[7] !== 1'b0 || d[1] !== 1'b1) begin
        n = n + 1;
        if (n > 1000) begin
          fail_count = fail_count + 1;
          give_verdict;
        end
        rrd(`NVMEPS_R_STATUS, d);
      end
    end
  endtask
  task cmd(input [6:0] c);
    rwr(`NVMEPS_R_CMD, {1'b0, c});
  endtask
  task run(input [6:0] c);
    begin
      cmd(c);
      rwr(`NVMEPS_R_CTRL_FIRST, 8'h01);
      wait_idle;
    end
  endtask
  task dop(input [6:0] c, input [15:0] a, input [7:0] v);
    begin
      cmd(c);
      prog.dwr(a, v);
      wait_idle;
    end
  endtask
  task rdchk(input [6:0] c, input [15:0] a, input [7:0] e);
    begin
      cmd(c);
      prog.drd(a, d);
      chk(d, e);
    end
  endtask
  // plain msb-first crc over n erased bytes
  function [15:0] crc_ff(input integer n);
    integer k;
    integer b;
    begin
      crc_ff = `NVMEPS_CRC_INIT;
      for (k = 0; k < n; k = k + 1) begin
        crc_ff = crc_ff ^ 16'hFF00;
        for (b = 0; b < 8; b = b + 1)
          crc_ff = crc_ff[15] ? ({crc_ff[14:0], 1'b0} ^ `NVMEPS_CRC_POLY) : {crc_ff[14:0], 1'b0};
      end
    end
  endfunction
  task crcchk(input [6:0] c, input integer n);
    begin
      run(c);
      crc = crc_ff(n);
      rrd(`NVMEPS_R_DATA_LO, d);
      chk(d, crc[7:0]);
      rrd(`NVMEPS_R_DATA_HI, d);
      chk(d, crc[15:8]);
    end
  endtask
  // ==========================================
  // main sequence
  initial begin
    rst = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    fail_count = 0;
    cmp_count = 0;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    rrd(`NVMEPS_R_CMD, d);
    chk(d, 8'h00);
    rrd(4'hF, d);
    chk(d, 8'h00);
    cmd(`NVMEPS_C_CHIP_ER);
    // external path: no protection unlock ahead of the execute bit
    rwr(`NVMEPS_R_CTRL_FIRST, 8'h01);
    rrd(`NVMEPS_R_STATUS, d);
    chk(d & 8'h82, 8'h80);
    wait_idle;
    rdchk(`NVMEPS_C_READ, 16'h0000, 8'hFF);
    rdchk(`NVMEPS_C_READ, 16'h5000, 8'hFF);
    rdchk(`NVMEPS_C_RD_PSIG, 16'h4003, 8'h59);
    run(`NVMEPS_C_ER_FBUF);
    cmd(`NVMEPS_C_LD_FBUF);
    prog.dword(16'h0010, 16'h2211);
    prog.dword(16'h0012, 16'h4433);
    dop(`NVMEPS_C_WR_APG, 16'h001F, 8'h00);
    rdchk(`NVMEPS_C_READ, 16'h0010, 8'h11);
    rdchk(`NVMEPS_C_READ, 16'h0013, 8'h44);
    rdchk(`NVMEPS_C_READ, 16'h0014, 8'hFF);
    cmd(`NVMEPS_C_ER_APG);
    prog.dwr(16'h0010, 8'h00);
    prog.drd(16'h0010, d);
    chk(d, 8'h00);
    wait_idle;
    rdchk(`NVMEPS_C_READ, 16'h0011, 8'hFF);
    dop(`NVMEPS_C_EW_BPG, 16'h00C5, 8'h00);
    rdchk(`NVMEPS_C_READ, 16'h00C1, 8'h22);
    rwr(`NVMEPS_R_ADDR_LO, 8'hC0);
    rwr(`NVMEPS_R_ADDR_HI, 8'h00);
    run(`NVMEPS_C_ER_BPG);
    rdchk(`NVMEPS_C_READ, 16'h00C1, 8'hFF);
    dop(`NVMEPS_C_EW_APG, 16'h0000, 8'h00);
    dop(`NVMEPS_C_ER_APP, 16'h0000, 8'h00);
    rdchk(`NVMEPS_C_READ, 16'h0000, 8'hFF);
    prog.slow = 3;
    run(`NVMEPS_C_ER_EBUF);
    cmd(`NVMEPS_C_LD_EBUF);
    prog.dwr(16'h1002, 8'hA5);
    dop(`NVMEPS_C_EW_EPG, 16'h1000, 8'h00);
    rdchk(`NVMEPS_C_RD_EE, 16'h1002, 8'hA5);
    rdchk(`NVMEPS_C_RD_EE, 16'h1003, 8'hFF);
    dop(`NVMEPS_C_ER_EE, 16'h1000, 8'h00);
    rdchk(`NVMEPS_C_RD_EE, 16'h1002, 8'hFF);
    dop(`NVMEPS_C_EW_EPG, 16'h1000, 8'h00);
    // program the preserve bit so the last chip erase keeps eeprom
    dop(`NVMEPS_C_WR_FUSE, 16'h2005, 8'hF7);
    cmd(`NVMEPS_C_RD_FUSE);
    prog.drd(16'h2005, d);
    chk(d & 8'h08, 8'h00);
    crcchk(`NVMEPS_C_ACRC, `NVMEPS_APP_END + 1);
    crcchk(`NVMEPS_C_BCRC, 64);
    dop(`NVMEPS_C_WR_LOCK, 16'h5000, 8'hFE);
    dop(`NVMEPS_C_WR_LOCK, 16'h5000, 8'hFF);
    rdchk(`NVMEPS_C_READ, 16'h5000, 8'hFE);
    dop(`NVMEPS_C_WR_LOCK, 16'h5000, 8'hFC);
    rrd(`NVMEPS_R_STATUS, d);
    chk(d, 8'h03);
    rdchk(`NVMEPS_C_READ, 16'h0000, 8'h00);
    crcchk(`NVMEPS_C_FCRC, `NVMEPS_FLASH_SZ);
    run(`NVMEPS_C_CHIP_ER);
    rrd(`NVMEPS_R_STATUS, d);
    chk(d, 8'h02);
    rdchk(`NVMEPS_C_RD_EE, 16'h1002, 8'hA5);
    give_verdict;
  end
endmodule
